// ---- cnod_node.sv ----
// Object dictionary, identifier set, guarding and fault lamps of the node
`timescale 1ns/10ps
`include "cnod_cfg.svh"
module cnod_node #(
    parameter int FLASH_CYCLES = `CNOD_FLASH_CYCLES,
    parameter int PAUSE_CYCLES = `CNOD_PAUSE_CYCLES,
    parameter int MS_CYCLES = `CNOD_MS_CYCLES,
    parameter logic [31:0] NAME_TEXT = 32'h4e4f4445,
    parameter logic [31:0] HWREV_TEXT = 32'h00000001,
    parameter logic [31:0] SWREV_TEXT = 32'h00000001,
    parameter logic [31:0] VENDOR_ID = 32'h00000001,
    parameter logic [31:0] PRODUCT_ID = 32'h00000002
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] addr_switch,
    input wire logic out_supply_ok,
    input wire logic valve_supply_ok,
    input wire logic mem_fail,
    input wire logic mem_done,
    input wire logic [31:0] input_states,
    input wire logic guard_rx,
    input wire cnod_pkg::cnod_req_s req,
    output logic [31:0] rdata,
    output logic ack,
    output logic abort,
    output cnod_pkg::cnod_ids_s ids,
    output logic [10:0] nmt_id,
    output logic [10:0] sync_id,
    output logic [6:0] node_addr,
    output logic guard_event,
    output logic [23:0] out_lines,
    output logic failure_count_lamp,
    output logic failure_select_lamp
);
    // Pin inputs except mem_done synchronised; first stage read only by second
    logic [5:0] sw_s1_q, sw_s2_q;
    logic [3:0] st_s1_q, st_s2_q;
    logic [31:0] in_s1_q, in_s2_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw_s1_q <= 6'h00;
            sw_s2_q <= 6'h00;
            st_s1_q <= 4'h3;
            st_s2_q <= 4'h3;
            in_s1_q <= 32'h0;
            in_s2_q <= 32'h0;
        end else begin
            sw_s1_q <= addr_switch;
            sw_s2_q <= sw_s1_q;
            st_s1_q <= {guard_rx, mem_fail, valve_supply_ok, out_supply_ok};
            st_s2_q <= st_s1_q;
            in_s1_q <= input_states;
            in_s2_q <= in_s1_q;
        end
    end
    logic out_ok, valve_ok, mem_bad, guard_sync, guard_prev_q;
    assign out_ok = st_s2_q[0];
    assign valve_ok = st_s2_q[1];
    assign mem_bad = st_s2_q[2];
    assign guard_sync = st_s2_q[3];

    // Registers
    logic [31:0] sync_q, emcy_q, sdo_rx_q, sdo_tx_q, rpdo_id_q, tpdo_id_q;
    logic [15:0] guard_q, holdoff_q, tinhibit_q, tevent_q;
    logic [7:0] life_q, eaddr_q, filter_q, imode_q, rtype_q, ttype_q;
    logic [23:0] outs_q, fmode_q, fstate_q;
    logic [31:0] rmap_q [3];
    logic [31:0] tmap_q [4];
    logic [7:0] addr_q;
    logic init_q;
    logic [2:0] boot_q;

    // Switch address 63 selects the stored address; taken once the synchroniser holds it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= 8'h00;
            init_q <= 1'b0;
            boot_q <= 3'h0;
        end else begin
            boot_q <= {boot_q[1:0], 1'b1};
            init_q <= (boot_q == 3'h1);
            if (init_q)
                addr_q <= (sw_s2_q == `CNOD_ADDR_SWITCH_MAX) ? eaddr_q : {2'b00, sw_s2_q};
        end
    end
    logic addr_bad;
    // No address fault before the address is taken, else every start-up would flash
    assign addr_bad = boot_q[2] && ((addr_q == 8'h00) || (addr_q > `CNOD_ADDR_MAX));
    assign node_addr = addr_q[6:0];

    function automatic logic [10:0] cob(input logic [10:0] base, input logic [7:0] a);
        cob = base + {4'h0, a[6:0]};
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ids <= '0;
            nmt_id <= 11'h000;
            sync_id <= 11'h000;
        end else begin
            nmt_id <= `CNOD_ID_NMT;
            sync_id <= sync_q[10:0];
            ids.emcy <= emcy_q[10:0];
            ids.tpdo <= tpdo_id_q[10:0];
            ids.rpdo <= rpdo_id_q[10:0];
            ids.tsdo <= sdo_tx_q[10:0];
            ids.rsdo <= sdo_rx_q[10:0];
            ids.guard <= cob(`CNOD_BASE_GUARD, addr_q);
        end
    end

    // Writes; identifier defaults reload one cycle after the address settles
    logic wr_ok;
    always_comb begin
        wr_ok = 1'b0;
        unique case (req.index)
            `CNOD_IDX_SYNC, `CNOD_IDX_GUARD, `CNOD_IDX_LIFE, `CNOD_IDX_EMCY,
            `CNOD_IDX_HOLDOFF, `CNOD_IDX_ADDR, `CNOD_IDX_FILTER,
            `CNOD_IDX_IMODE: wr_ok = (req.sub == 8'h00);
            `CNOD_IDX_SDO: wr_ok = (req.sub == 8'h01) || (req.sub == 8'h02);
            `CNOD_IDX_RPDO: wr_ok = (req.sub == 8'h01) || (req.sub == 8'h02);
            `CNOD_IDX_RMAP: wr_ok = (req.sub >= 8'h01) && (req.sub <= 8'h03);
            `CNOD_IDX_TPDO: wr_ok = (req.sub >= 8'h01 && req.sub <= 8'h03) ||
                (req.sub == 8'h05);
            `CNOD_IDX_TMAP: wr_ok = (req.sub >= 8'h01) && (req.sub <= 8'h04);
            `CNOD_IDX_OUTS, `CNOD_IDX_FMODE, `CNOD_IDX_FSTATE:
                wr_ok = (req.sub >= 8'h01) && (req.sub <= 8'h03);
            default: wr_ok = 1'b0;
        endcase
    end
    logic load_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            load_q <= 1'b0;
        else
            load_q <= init_q;
    end
    logic w;
    logic [1:0] s2;
    assign w = req.wr && wr_ok;
    assign s2 = req.sub[1:0] - 2'd1;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_q <= `CNOD_SYNC_RST;
            guard_q <= `CNOD_GUARD_RST;
            life_q <= `CNOD_LIFE_RST;
            emcy_q <= 32'h0;
            holdoff_q <= 16'h0;
            eaddr_q <= `CNOD_ADDR_RST;
            filter_q <= `CNOD_FILTER_RST;
            imode_q <= `CNOD_IMODE_RST;
            sdo_rx_q <= 32'h0;
            sdo_tx_q <= 32'h0;
            rpdo_id_q <= 32'h0;
            tpdo_id_q <= 32'h0;
            rtype_q <= 8'hff;
            ttype_q <= 8'hff;
            tinhibit_q <= 16'h0;
            tevent_q <= 16'h0;
            outs_q <= 24'h0;
            fmode_q <= 24'h0;
            fstate_q <= 24'h0;
            for (int i = 0; i < 3; i++)
                rmap_q[i] <= {`CNOD_IDX_OUTS, 8'(i + 1), 8'h08};
            for (int i = 0; i < 4; i++)
                tmap_q[i] <= {`CNOD_IDX_INPUTS, 8'(i + 1), 8'h08};
        end else if (load_q) begin
            emcy_q <= {21'h0, cob(`CNOD_BASE_EMCY, addr_q)};
            tpdo_id_q <= {21'h0, cob(`CNOD_BASE_TPDO, addr_q)};
            rpdo_id_q <= {21'h0, cob(`CNOD_BASE_RPDO, addr_q)};
            sdo_tx_q <= {21'h0, cob(`CNOD_BASE_TSDO, addr_q)};
            sdo_rx_q <= {21'h0, cob(`CNOD_BASE_RSDO, addr_q)};
        end else if (w) begin
            unique case (req.index)
                `CNOD_IDX_SYNC: sync_q <= req.wdata;
                `CNOD_IDX_GUARD: guard_q <= req.wdata[15:0];
                `CNOD_IDX_LIFE: life_q <= req.wdata[7:0];
                `CNOD_IDX_EMCY: emcy_q <= req.wdata;
                `CNOD_IDX_HOLDOFF: holdoff_q <= req.wdata[15:0];
                `CNOD_IDX_ADDR: eaddr_q <= req.wdata[7:0];
                `CNOD_IDX_FILTER: filter_q <= req.wdata[7:0];
                `CNOD_IDX_IMODE: imode_q <= req.wdata[7:0];
                `CNOD_IDX_SDO:
                    if (req.sub == 8'h01)
                        sdo_rx_q <= req.wdata;
                    else
                        sdo_tx_q <= req.wdata;
                `CNOD_IDX_RPDO:
                    if (req.sub == 8'h01)
                        rpdo_id_q <= req.wdata;
                    else
                        rtype_q <= req.wdata[7:0];
                `CNOD_IDX_RMAP: rmap_q[s2] <= req.wdata;
                `CNOD_IDX_TPDO:
                    unique case (req.sub)
                        8'h01: tpdo_id_q <= req.wdata;
                        8'h02: ttype_q <= req.wdata[7:0];
                        8'h03: tinhibit_q <= req.wdata[15:0];
                        default: tevent_q <= req.wdata[15:0];
                    endcase
                `CNOD_IDX_TMAP: tmap_q[s2] <= req.wdata;
                `CNOD_IDX_OUTS: outs_q[8*s2 +: 8] <= req.wdata[7:0];
                `CNOD_IDX_FMODE: fmode_q[8*s2 +: 8] <= req.wdata[7:0];
                `CNOD_IDX_FSTATE: fstate_q[8*s2 +: 8] <= req.wdata[7:0];
                default: ;
            endcase
        end
    end

    // Guarding: lifetime = guard time x factor, counted in milliseconds
    logic [15:0] ms_cnt_q;
    logic [23:0] life_cnt_q;
    logic [23:0] lifetime;
    logic guard_edge;
    assign lifetime = guard_q * life_q;
    assign guard_edge = guard_sync && !guard_prev_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            guard_prev_q <= 1'b0;
            ms_cnt_q <= 16'h0;
            life_cnt_q <= 24'h0;
            guard_event <= 1'b0;
        end else begin
            guard_prev_q <= guard_sync;
            if (guard_q == 16'h0 || life_q == 8'h00 || guard_edge) begin
                ms_cnt_q <= 16'h0;
                life_cnt_q <= 24'h0;
                guard_event <= 1'b0;
            end else if (ms_cnt_q == 16'(MS_CYCLES - 1)) begin
                ms_cnt_q <= 16'h0;
                if (life_cnt_q >= lifetime - 24'd1)
                    guard_event <= 1'b1;
                else
                    life_cnt_q <= life_cnt_q + 24'd1;
            end else begin
                ms_cnt_q <= ms_cnt_q + 16'd1;
            end
        end
    end

    // Fault flags and outputs; guard loss applies fault values per mode
    logic [7:0] fault_flags;
    always_comb begin
        fault_flags = 8'h00;
        fault_flags[`CNOD_FB_GENERAL] = !out_ok || addr_bad || mem_bad;
        fault_flags[`CNOD_FB_VALVE] = !valve_ok;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            out_lines <= 24'h0;
        else if (guard_event)
            out_lines <= (outs_q & ~fmode_q) | (fstate_q & fmode_q);
        else
            out_lines <= outs_q;
    end

    // Reads
    logic [31:0] rd_d;
    logic rd_ok;
    always_comb begin
        rd_d = 32'h0;
        rd_ok = (req.sub == 8'h00);
        unique case (req.index)
            `CNOD_IDX_DEV_TYPE: rd_d = `CNOD_DEV_TYPE;
            `CNOD_IDX_FAULT: rd_d = {24'h0, fault_flags};
            `CNOD_IDX_SYNC: rd_d = sync_q;
            `CNOD_IDX_NAME: rd_d = NAME_TEXT;
            `CNOD_IDX_HWREV: rd_d = HWREV_TEXT;
            `CNOD_IDX_SWREV: rd_d = SWREV_TEXT;
            `CNOD_IDX_GUARD: rd_d = {16'h0, guard_q};
            `CNOD_IDX_LIFE: rd_d = {24'h0, life_q};
            `CNOD_IDX_EMCY: rd_d = emcy_q;
            `CNOD_IDX_HOLDOFF: rd_d = {16'h0, holdoff_q};
            `CNOD_IDX_ADDR: rd_d = {24'h0, eaddr_q};
            `CNOD_IDX_FILTER: rd_d = {24'h0, filter_q};
            `CNOD_IDX_IMODE: rd_d = {24'h0, imode_q};
            `CNOD_IDX_IDENT: begin
                rd_ok = (req.sub <= 8'h04);
                unique case (req.sub)
                    8'h00: rd_d = 32'h4;
                    8'h01: rd_d = VENDOR_ID; // Arbitrary identity value
                    8'h02: rd_d = PRODUCT_ID; // Arbitrary identity value
                    default: rd_d = 32'h0;
                endcase
            end
            `CNOD_IDX_SDO: begin
                rd_ok = (req.sub <= 8'h02);
                rd_d = (req.sub == 8'h00) ? 32'h2 : (req.sub == 8'h01) ? sdo_rx_q : sdo_tx_q;
            end
            `CNOD_IDX_RPDO: begin
                rd_ok = (req.sub <= 8'h02);
                rd_d = (req.sub == 8'h00) ? 32'h2 :
                    (req.sub == 8'h01) ? rpdo_id_q : {24'h0, rtype_q};
            end
            `CNOD_IDX_RMAP: begin
                rd_ok = (req.sub <= 8'h03);
                rd_d = (req.sub == 8'h00) ? 32'h3 : rmap_q[s2];
            end
            `CNOD_IDX_TPDO: begin
                rd_ok = (req.sub <= 8'h03) || (req.sub == 8'h05);
                unique case (req.sub)
                    8'h00: rd_d = 32'h5;
                    8'h01: rd_d = tpdo_id_q;
                    8'h02: rd_d = {24'h0, ttype_q};
                    8'h03: rd_d = {16'h0, tinhibit_q};
                    default: rd_d = {16'h0, tevent_q};
                endcase
            end
            `CNOD_IDX_TMAP: begin
                rd_ok = (req.sub <= 8'h04);
                rd_d = (req.sub == 8'h00) ? 32'h4 : tmap_q[s2];
            end
            `CNOD_IDX_INPUTS: begin
                rd_ok = (req.sub <= 8'h04);
                rd_d = (req.sub == 8'h00) ? 32'h4 : {24'h0, in_s2_q[8*s2 +: 8]};
            end
            `CNOD_IDX_OUTS, `CNOD_IDX_FMODE, `CNOD_IDX_FSTATE: begin
                rd_ok = (req.sub <= 8'h03);
                if (req.sub == 8'h00)
                    rd_d = 32'h3;
                else if (req.index == `CNOD_IDX_OUTS)
                    rd_d = {24'h0, outs_q[8*s2 +: 8]};
                else if (req.index == `CNOD_IDX_FMODE)
                    rd_d = {24'h0, fmode_q[8*s2 +: 8]};
                else
                    rd_d = {24'h0, fstate_q[8*s2 +: 8]};
            end
            default: rd_ok = 1'b0;
        endcase
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0;
            ack <= 1'b0;
            abort <= 1'b0;
        end else begin
            rdata <= (req.rd && rd_ok) ? rd_d : 32'h0;
            ack <= (req.rd && rd_ok) || w;
            abort <= (req.rd && !rd_ok) || (req.wr && !wr_ok);
        end
    end

    // Fault lamps: select lit for type count, dark for number count
    logic mem_seen_q, mem_shown_q, part_q;
    logic [3:0] code_type, code_num, left_q;
    logic [31:0] tmr_q;
    logic show_mem, active;
    cnod_pkg::cnod_flash_e fl_q;
    assign show_mem = mem_seen_q && !mem_shown_q;
    assign active = show_mem || !out_ok || addr_bad;
    always_comb begin
        code_type = `CNOD_ERR_MAIN;
        code_num = `CNOD_ERR_NO_SUPPLY;
        if (show_mem) begin
            code_type = `CNOD_ERR_MEM;
            code_num = `CNOD_ERR_MEM_NUM;
        end else if (out_ok)
            code_num = `CNOD_ERR_BAD_ADDR;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            mem_seen_q <= 1'b0;
        else if (mem_done && mem_bad)
            mem_seen_q <= 1'b1;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fl_q <= cnod_pkg::CNOD_IDLE;
            tmr_q <= 32'h0;
            left_q <= 4'h0;
            part_q <= 1'b0;
            mem_shown_q <= 1'b0;
            failure_count_lamp <= 1'b0;
            failure_select_lamp <= 1'b0;
        end else begin
            tmr_q <= (tmr_q == 32'h0) ? 32'h0 : tmr_q - 32'd1;
            unique case (fl_q)
                cnod_pkg::CNOD_IDLE:
                    if (active) begin
                        fl_q <= cnod_pkg::CNOD_SEL;
                        part_q <= 1'b0;
                        failure_select_lamp <= 1'b1;
                        left_q <= code_type;
                        tmr_q <= 32'(PAUSE_CYCLES);
                    end else
                        failure_select_lamp <= 1'b0;
                cnod_pkg::CNOD_SEL:
                    if (tmr_q == 32'h0) begin
                        fl_q <= cnod_pkg::CNOD_ON;
                        failure_count_lamp <= 1'b1;
                        tmr_q <= 32'(FLASH_CYCLES);
                    end
                cnod_pkg::CNOD_ON:
                    if (tmr_q == 32'h0) begin
                        fl_q <= cnod_pkg::CNOD_OFF;
                        failure_count_lamp <= 1'b0;
                        left_q <= left_q - 4'd1;
                        tmr_q <= 32'(FLASH_CYCLES);
                    end
                cnod_pkg::CNOD_OFF:
                    if (tmr_q == 32'h0) begin
                        if (left_q != 4'h0) begin
                            fl_q <= cnod_pkg::CNOD_ON;
                            failure_count_lamp <= 1'b1;
                            tmr_q <= 32'(FLASH_CYCLES);
                        end else begin
                            fl_q <= cnod_pkg::CNOD_GAP;
                            tmr_q <= 32'(PAUSE_CYCLES);
                        end
                    end
                cnod_pkg::CNOD_GAP:
                    if (tmr_q == 32'h0) begin
                        if (!part_q) begin
                            part_q <= 1'b1;
                            failure_select_lamp <= 1'b0;
                            left_q <= code_num;
                            fl_q <= cnod_pkg::CNOD_SEL;
                            tmr_q <= 32'(PAUSE_CYCLES);
                        end else begin
                            if (show_mem)
                                mem_shown_q <= 1'b1;
                            fl_q <= cnod_pkg::CNOD_IDLE;
                        end
                    end
                default: fl_q <= cnod_pkg::CNOD_IDLE;
            endcase
        end
    end
endmodule // cnod_node

// ---- cnod_cfg.svh ----
// Constants for the CANopen node object dictionary block
`ifndef CNOD_CFG_SVH
`define CNOD_CFG_SVH
`define CNOD_IDX_DEV_TYPE 16'h1000
`define CNOD_IDX_FAULT 16'h1001
`define CNOD_IDX_SYNC 16'h1005
`define CNOD_IDX_NAME 16'h1008
`define CNOD_IDX_HWREV 16'h1009
`define CNOD_IDX_SWREV 16'h100a
`define CNOD_IDX_GUARD 16'h100c
`define CNOD_IDX_LIFE 16'h100d
`define CNOD_IDX_EMCY 16'h1014
`define CNOD_IDX_HOLDOFF 16'h1015
`define CNOD_IDX_IDENT 16'h1018
`define CNOD_IDX_SDO 16'h1200
`define CNOD_IDX_RPDO 16'h1400
`define CNOD_IDX_RMAP 16'h1600
`define CNOD_IDX_TPDO 16'h1800
`define CNOD_IDX_TMAP 16'h1a00
`define CNOD_IDX_ADDR 16'h3000
`define CNOD_IDX_INPUTS 16'h6000
`define CNOD_IDX_FILTER 16'h6003
`define CNOD_IDX_IMODE 16'h601f
`define CNOD_IDX_OUTS 16'h6200
`define CNOD_IDX_FMODE 16'h6206
`define CNOD_IDX_FSTATE 16'h6207
`define CNOD_DEV_TYPE 32'h0000401d
`define CNOD_SYNC_RST 32'h00000080
`define CNOD_GUARD_RST 16'h01f4
`define CNOD_LIFE_RST 8'h03
`define CNOD_ADDR_RST 8'h3f
`define CNOD_FILTER_RST 8'h01
`define CNOD_IMODE_RST 8'h00
`define CNOD_FB_GENERAL 0
`define CNOD_FB_VALVE 2
`define CNOD_ID_NMT 11'h000
`define CNOD_ID_SYNC 11'h080
`define CNOD_BASE_EMCY 11'h080
`define CNOD_BASE_TPDO 11'h180
`define CNOD_BASE_RPDO 11'h200
`define CNOD_BASE_TSDO 11'h580
`define CNOD_BASE_RSDO 11'h600
`define CNOD_BASE_GUARD 11'h700
`define CNOD_ADDR_SWITCH_MAX 6'h3f
`define CNOD_ADDR_MAX 8'h7f
`define CNOD_ERR_MAIN 4'h3
`define CNOD_ERR_NO_SUPPLY 4'h1
`define CNOD_ERR_BAD_ADDR 4'h2
`define CNOD_ERR_MEM 4'h5
`define CNOD_ERR_MEM_NUM 4'h1
`define CNOD_CLK_HZ 20000000
`define CNOD_MS_CYCLES (`CNOD_CLK_HZ / 1000)
`define CNOD_FLASH_MS 250
`define CNOD_PAUSE_MS 1500
`define CNOD_FLASH_CYCLES (`CNOD_FLASH_MS * `CNOD_MS_CYCLES)
`define CNOD_PAUSE_CYCLES (`CNOD_PAUSE_MS * `CNOD_MS_CYCLES)
`endif

// ---- cnod_pkg.sv ----
// Types for the CANopen node object dictionary block
package cnod_pkg;
    typedef struct packed {
        logic [10:0] emcy;
        logic [10:0] tpdo;
        logic [10:0] rpdo;
        logic [10:0] tsdo;
        logic [10:0] rsdo;
        logic [10:0] guard;
    } cnod_ids_s;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } cnod_req_s;
    typedef enum logic [2:0] {
        CNOD_IDLE = 3'b000,
        CNOD_SEL = 3'b001,
        CNOD_ON = 3'b011,
        CNOD_OFF = 3'b010,
        CNOD_GAP = 3'b110
    } cnod_flash_e;
endpackage

// ---- cnod_node_monitor.sv ----
// Port checker for the node object dictionary
`timescale 1ns/10ps
module cnod_node_monitor #(
    parameter int FLASH_CYCLES = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire cnod_pkg::cnod_req_s req,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic abort,
    input wire cnod_pkg::cnod_ids_s ids,
    input wire logic [10:0] nmt_id,
    input wire logic [6:0] node_addr,
    input wire logic failure_count_lamp
);
    logic [2:0] up_q;
    logic [31:0] run_q;
    // Identifiers are only meaningful once the start-up steps have run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) up_q <= 3'h0;
        else if (up_q != 3'h5) up_q <= up_q + 3'h1;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) run_q <= 32'h0;
        else run_q <= failure_count_lamp ? run_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_take;
        req.rd || req.wr;
    endsequence
    sequence s_dev_read;
        req.rd && !req.wr && req.index == 16'h1000 && req.sub == 8'h00;
    endsequence
    chk_req_answered: assert property (s_take |=> ack != abort)
        else $error("request without single answer");
    chk_idle_quiet: assert property (!(req.rd || req.wr) |=> !ack && !abort)
        else $error("answer without request");
    chk_rdata_idle: assert property (!ack |-> rdata == 32'h0)
        else $error("read data outside answer");
    chk_dev_type: assert property (s_dev_read |=> ack && rdata == 32'h0000401d)
        else $error("device type value wrong");
    chk_ro_write: assert property (req.wr && req.index == 16'h1000 |=> abort)
        else $error("read-only write accepted");
    chk_flags_unused: assert property (req.rd && !req.wr && req.index == 16'h1001
        |=> rdata[7:3] == 5'h0 && !rdata[1])
        else $error("unused fault bit set");
    chk_tpdo_gap: assert property (s_take and req.index == 16'h1800 && req.sub == 8'h04
        |=> abort)
        else $error("absent sub-index answered");
    chk_nmt_fixed: assert property (nmt_id == 11'h000)
        else $error("management id not zero");
    chk_guard_id: assert property (up_q == 3'h5 |-> ids.guard == 11'h700 + 11'(node_addr))
        else $error("guarding id wrong");
    // The timer's zero cycle adds one cycle to every lit span
    chk_flash_len: assert property ($fell(failure_count_lamp) |-> run_q == FLASH_CYCLES + 1)
        else $error("flash length wrong");
endmodule // cnod_node_monitor
bind cnod_node cnod_node_monitor #(.FLASH_CYCLES(FLASH_CYCLES)) mon_u (.clk(clk),
    .resetn(resetn), .req(req), .rdata(rdata), .ack(ack), .abort(abort), .ids(ids),
    .nmt_id(nmt_id), .node_addr(node_addr), .failure_count_lamp(failure_count_lamp));

// ---- cnod_master.sv ----
// Network master model sending periodic guarding requests
`timescale 1ns/10ps
module cnod_master (
    input wire logic clk,
    input wire logic resetn,
    input wire logic guard_on,
    input wire logic [7:0] gap,
    output logic guard_rx
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) cnt_q <= 8'h00;
        else cnt_q <= (cnt_q == gap) ? 8'h00 : cnt_q + 8'h01;
    end
    // Two-cycle pulse so the node's synchroniser cannot miss it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) guard_rx <= 1'b0;
        else guard_rx <= guard_on && cnt_q < 8'h02;
    end
endmodule // cnod_master

// ---- test_canopen_node_object_dictionary.sv ----
// Self-checking bench for the node object dictionary
`timescale 1ns/10ps
module test_canopen_node_object_dictionary;
    logic clk, resetn, out_ok, valve_ok, mem_fail, mem_done, guard_on, guard_rx;
    logic ack, abort, guard_event, cnt_lamp, sel_lamp;
    logic [5:0] sw;
    logic [31:0] ins, rdata, v;
    logic [23:0] outs;
    logic [10:0] nmt, syn;
    logic [6:0] naddr;
    cnod_pkg::cnod_req_s req;
    cnod_pkg::cnod_ids_s ids;
    int bad_count = 0, num_checks = 0, n;
    cnod_node #(.FLASH_CYCLES(4), .PAUSE_CYCLES(12), .MS_CYCLES(10)) dut_u (.clk(clk),
        .resetn(resetn), .addr_switch(sw), .out_supply_ok(out_ok), .valve_supply_ok(valve_ok),
        .mem_fail(mem_fail), .mem_done(mem_done), .input_states(ins), .guard_rx(guard_rx),
        .req(req), .rdata(rdata), .ack(ack), .abort(abort), .ids(ids), .nmt_id(nmt),
        .sync_id(syn), .node_addr(naddr), .guard_event(guard_event), .out_lines(outs),
        .failure_count_lamp(cnt_lamp), .failure_select_lamp(sel_lamp));
    cnod_master mst_u (.clk(clk), .resetn(resetn), .guard_on(guard_on), .gap(8'h14),
        .guard_rx(guard_rx));
    initial begin clk = 0; forever #25 clk = ~clk; end
    task stop_test;
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task do_reset;
        @(negedge clk) resetn = 0;
        repeat (5) @(negedge clk);
        resetn = 1;
        repeat (5) @(negedge clk);
    endtask
    // One idle cycle after each access keeps every request a single cycle
    task access(input logic w, input logic [15:0] idx, input logic [7:0] sb,
        input logic [31:0] d, input logic ok);
        req = '{rd: !w, wr: w, index: idx, sub: sb, wdata: d};
        @(negedge clk);
        req = '0;
        check_val({ack, abort}, {ok, !ok});
        v = rdata;
        @(negedge clk);
    endtask
    task rd(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] exp);
        access(0, idx, sb, 32'h0, 1);
        check_val(v, exp);
    endtask
    task count(input logic lvl);
        logic p;
        n = 0;
        p = cnt_lamp;
        for (int i = 0; i < 300 && sel_lamp === lvl; i++) begin
            @(negedge clk);
            if (cnt_lamp === 1 && p !== 1) n++;
            p = cnt_lamp;
        end
    endtask
    task show_err(input logic [31:0] t, input logic [31:0] num);
        for (int i = 0; i < 50 && sel_lamp !== 1; i++) @(negedge clk);
        count(1);
        check_val(n, t);
        count(0);
        check_val(n, num);
    endtask
    initial begin
        resetn = 0; req = '0; sw = 6'h05; out_ok = 1; valve_ok = 1; mem_fail = 0;
        mem_done = 1; ins = 32'h44332211; guard_on = 1;
        do_reset;
        rd(16'h1000, 8'h00, 32'h401d);
        rd(16'h1005, 8'h00, 32'h80);
        rd(16'h100c, 8'h00, 32'h1f4);
        rd(16'h100d, 8'h00, 32'h3);
        rd(16'h1014, 8'h00, 32'h85);
        rd(16'h1800, 8'h01, 32'h185);
        rd(16'h1400, 8'h01, 32'h205);
        rd(16'h1200, 8'h01, 32'h605);
        rd(16'h1200, 8'h02, 32'h585);
        rd(16'h1800, 8'h05, 32'h0);
        rd(16'h6000, 8'h02, 32'h22);
        rd(16'h3000, 8'h00, 32'h3f);
        rd(16'h1001, 8'h00, 32'h0);
        check_val(nmt, 32'h0);
        check_val({ids.guard, ids.tpdo}, {11'h705, 11'h185});
        check_val(naddr, 32'h5);
        access(1, 16'h1000, 8'h00, 32'h1, 0);
        access(1, 16'h1800, 8'h04, 32'h1, 0);
        access(1, 16'h6000, 8'h01, 32'h1, 0);
        access(1, 16'h1008, 8'h00, 32'h1, 0);
        access(0, 16'h100b, 8'h00, 32'h0, 0);
        access(1, 16'h6200, 8'h00, 32'h1, 0);
        access(1, 16'h6200, 8'h02, 32'ha5, 1);
        check_val(outs, 32'ha500);
        access(1, 16'h1005, 8'h00, 32'h81, 1);
        check_val(syn, 32'h81);
        access(1, 16'h6003, 8'h00, 32'h0, 1);
        rd(16'h6003, 8'h00, 32'h0);
        valve_ok = 0;
        repeat (4) @(negedge clk);
        rd(16'h1001, 8'h00, 32'h4);
        valve_ok = 1;
        access(1, 16'h100c, 8'h00, 32'h2, 1);
        repeat (100) @(negedge clk);
        check_val(guard_event, 32'h0);
        guard_on = 0;
        repeat (90) @(negedge clk);
        check_val(guard_event, 32'h1);
        access(1, 16'h100c, 8'h00, 32'h0, 1);
        repeat (5) @(negedge clk);
        check_val(guard_event, 32'h0);
        out_ok = 0;
        show_err(3, 1);
        out_ok = 1;
        sw = 6'h00;
        do_reset;
        show_err(3, 2);
        rd(16'h1001, 8'h00, 32'h1);
        sw = 6'h05;
        mem_fail = 1;
        do_reset;
        show_err(5, 1);
        check_val(sel_lamp, 32'h0);
        rd(16'h100d, 8'h00, 32'h3);
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test;
    end
endmodule // test_canopen_node_object_dictionary
